// *** spi_port_pkg.sv ***
// constants shared by the synchronous serial port files
// assumes a 10 MHz core clock and no register bus
package spi_port_pkg;
	// mode_select encodings
	localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
	localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
	localparam logic [3:0] MODE_MASTER_TMR2  = 4'h3;
	localparam logic [3:0] MODE_SLAVE_SEL    = 4'h4;
	localparam logic [3:0] MODE_SLAVE_NOSEL  = 4'h5;
	localparam logic [3:0] MODE_MASTER_RELOAD = 4'ha;
	// control_reg1 field positions
	localparam int CR1_WRITE_COLLISION_BIT  = 7;
	localparam int CR1_EN_BIT    = 5;
	localparam int CR1_CKP_BIT   = 4;
	// status_reg field positions
	localparam int ST_SMP_BIT    = 7;
	localparam int ST_CKE_BIT    = 6;
	localparam int ST_BF_BIT     = 0;
	// half-period counts in core clocks per rate
	localparam logic [7:0] HALF_DIV4  = 8'h02;
	localparam logic [7:0] HALF_DIV16 = 8'h08;
	localparam logic [7:0] HALF_DIV64 = 8'h20;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
endpackage : spi_port_pkg

// *** pin_sync.sv ***
// three-stage synchroniser for an external pin
// assumes a single core clock
`timescale 1ns/100ps
module pin_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1;
	logic s2;
	logic s3;
	// second and third stage must agree before change
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			level_o <= INIT;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level_o <= s3;
			end
		end
	end
endmodule : pin_sync

// *** sck_gen.sv ***
// master serial-clock half-period tick generator
// assumes a core clock and a synchronised timer_two pulse
`timescale 1ns/100ps
module sck_gen (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [3:0] mode_i,
	input  wire logic [7:0] baud_reload_i,
	input  wire logic       tmr2_tick_i,
	output logic            half_tick_o
);
	logic [8:0] cnt;
	logic [8:0] limit;
	logic       use_tmr;
	// rate selection
	assign use_tmr = (mode_i == spi_port_pkg::MODE_MASTER_TMR2);
	assign limit = (mode_i == spi_port_pkg::MODE_MASTER_DIV16) ? {1'b0, spi_port_pkg::HALF_DIV16} :
		(mode_i == spi_port_pkg::MODE_MASTER_DIV64) ? {1'b0, spi_port_pkg::HALF_DIV64} :
		(mode_i == spi_port_pkg::MODE_MASTER_RELOAD) ? {baud_reload_i, 1'b0} + 9'h002 :
		{1'b0, spi_port_pkg::HALF_DIV4};
	assign half_tick_o = use_tmr ? (run_i & tmr2_tick_i) : (run_i && cnt == limit - 9'h001);
	// count core clocks per half period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 9'h000;
		end else if (!run_i || half_tick_o || use_tmr) begin
			cnt <= 9'h000;
		end else begin
			cnt <= cnt + 9'h001;
		end
	end
endmodule : sck_gen

// *** spi_master_slave_port.sv ***
// spi part of a synchronous serial port, master and slave
// assumes control bits arrive as ports and pins are tri-stated outside
`timescale 1ns/100ps
module spi_master_slave_port (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control_reg1 / status_reg / control_reg3 bits
	input  wire logic       port_enable_i,
	input  wire logic       clock_polarity_i,
	input  wire logic [3:0] mode_select_i,
	input  wire logic       sample_phase_i,
	input  wire logic       clock_edge_select_i,
	input  wire logic       overwrite_enable_i,
	input  wire logic [7:0] baud_reload_i,
	input  wire logic       timer_two_tick_i,
	input  wire logic       sleep_i,
	// software access to data_buffer
	input  wire logic       buf_write_i,
	input  wire logic [7:0] buf_wdata_i,
	input  wire logic       buf_read_i,
	input  wire logic       write_collision_clear_i,
	input  wire logic       xfer_flag_clear_i,
	output logic [7:0]      data_buffer_o,
	output logic            buffer_full_o,
	output logic            write_collision_o,
	output logic            xfer_flag_o,
	output logic            busy_o,
	// serial pins
	input  wire logic       sck_i,
	output logic            sck_o,
	output logic            sck_oe_n_o,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	output logic            sdo_oe_n_o,
	input  wire logic       ss_n_i
);
	typedef enum {ST_IDLE, ST_LEAD, ST_TRAIL} mstate_t;

	// ==========================================================
	// mode decode
	// ==========================================================
	logic is_master;
	logic is_slave;
	logic use_ss;
	logic en;
	// master for rate codes, slave for 0100/0101
	assign en       = port_enable_i;
	assign is_slave = (mode_select_i == spi_port_pkg::MODE_SLAVE_SEL) ||
		(mode_select_i == spi_port_pkg::MODE_SLAVE_NOSEL);
	assign is_master = !is_slave;
	assign use_ss   = (mode_select_i == spi_port_pkg::MODE_SLAVE_SEL);

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic sck_s;
	logic sdi_s;
	logic ss_n_s;
	logic tmr_s;
	logic tmr_d;
	pin_sync #(
		.INIT(1'b0)
	) u_sck (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (sck_i),
		.level_o(sck_s)
	);
	pin_sync #(
		.INIT(1'b0)
	) u_sdi (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (sdi_i),
		.level_o(sdi_s)
	);
	pin_sync #(
		.INIT(1'b1)
	) u_ss (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (ss_n_i),
		.level_o(ss_n_s)
	);
	pin_sync #(
		.INIT(1'b0)
	) u_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (timer_two_tick_i),
		.level_o(tmr_s)
	);
	logic sdi_bit;
	// master input is launched by our own clock: the synchroniser delay would eat a fast bit
	assign sdi_bit = is_master ? sdi_i : sdi_s;

	// ==========================================================
	// slave select and module reset
	// ==========================================================
	logic ss_active;
	logic mod_reset;
	assign ss_active = !use_ss || !ss_n_s;
	// select high in the slave-with-select mode (0100), or disable, resets the engine
	assign mod_reset = !en || (is_slave && use_ss && ss_n_s);

	// ==========================================================
	// master clock generation
	// ==========================================================
	mstate_t    mstate;
	mstate_t    next_mstate;
	logic       half_tick;
	logic       tmr_edge;
	logic       m_run;
	logic [3:0] pulse_cnt;
	// timer_two toggles once per output; only rising edges tick, so the output rate is quartered
	assign tmr_edge = tmr_s & ~tmr_d;
	assign m_run    = en && is_master && (mstate != ST_IDLE);
	sck_gen u_gen (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.run_i        (m_run),
		.mode_i       (mode_select_i),
		.baud_reload_i(baud_reload_i),
		.tmr2_tick_i  (tmr_edge),
		.half_tick_o  (half_tick)
	);

	// ==========================================================
	// shift engine
	// ==========================================================
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt;
	logic       sck_int;
	logic       sck_prev;
	logic       lead_edge;
	logic       trail_edge;
	logic       sampled;
	logic       in_bit;
	logic       sclk_level;
	logic       byte_done;
	logic       accept_write;
	logic       write_try;
	logic       xfer_busy;
	// internal clock: master own, slave from pin
	// serial clock level differs from the last sampled one
	function automatic logic level_moved(input logic now_lvl, input logic was_lvl);
		return now_lvl != was_lvl;
	endfunction : level_moved
	assign sclk_level = is_master ? sck_int : sck_s;
	assign lead_edge  = en && ss_active && level_moved(sclk_level, sck_prev) && (sclk_level != clock_polarity_i);
	assign trail_edge = en && ss_active && level_moved(sclk_level, sck_prev) && (sclk_level == clock_polarity_i);
	// busy once first bit counted or master started
	assign xfer_busy  = (bit_cnt != 4'h0) || (is_master && mstate != ST_IDLE);
	assign write_try  = buf_write_i && en;
	// no write while busy or while collision pending
	assign accept_write = write_try && !xfer_busy && !write_collision_o &&
		(overwrite_enable_i || 1'b1);
	assign busy_o = xfer_busy;

	// sample edge: cke=1 samples leading, cke=0 samples trailing
	logic sample_edge;
	logic shift_edge;
	assign sample_edge = clock_edge_select_i ? lead_edge : trail_edge;
	assign shift_edge  = clock_edge_select_i ? trail_edge : lead_edge;
	// end-phase sampling in master latches data at the sample edge and shifts it in at the shift edge
	logic late_sample;
	assign late_sample = is_master && sample_phase_i;
	assign byte_done   = (late_sample ? shift_edge : sample_edge) && (bit_cnt == spi_port_pkg::BITS_PER_BYTE - 4'h1);

	// master sequencer
	always_comb begin
		next_mstate = mstate;
		case (mstate)
			ST_IDLE: begin
				if (accept_write && is_master) begin
					next_mstate = ST_LEAD;
				end
			end
			ST_LEAD: begin
				if (half_tick) begin
					next_mstate = ST_TRAIL;
				end
			end
			ST_TRAIL: begin
				if (half_tick) begin
					// stop after eight pulses, whatever the sampling mode
					next_mstate = (pulse_cnt == spi_port_pkg::BITS_PER_BYTE) ? ST_IDLE : ST_LEAD;
				end
			end
			default: begin
				next_mstate = ST_IDLE;
			end
		endcase
		if (!en || !is_master) begin
			next_mstate = ST_IDLE;
		end
	end

	// master sequencer state and clock level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mstate    <= ST_IDLE;
			sck_int   <= 1'b0;
			tmr_d     <= 1'b0;
			pulse_cnt <= 4'h0;
		end else begin
			mstate  <= next_mstate;
			tmr_d   <= tmr_s;
			// active-going half ticks counted per byte
			if (next_mstate == ST_IDLE) begin
				pulse_cnt <= 4'h0;
			end else if (mstate == ST_LEAD && half_tick) begin
				pulse_cnt <= pulse_cnt + 4'h1;
			end
			if (next_mstate == ST_IDLE || !en) begin
				sck_int <= clock_polarity_i;
			end else if (half_tick) begin
				sck_int <= ~sck_int;
			end
		end
	end

	// edge tracking
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_prev <= 1'b0;
		end else if (!en) begin
			sck_prev <= clock_polarity_i;
		end else begin
			sck_prev <= sclk_level;
		end
	end

	// shift register and bit counter, msb first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_reg <= spi_port_pkg::RESET_BYTE;
			bit_cnt   <= 4'h0;
			in_bit    <= 1'b0;
			sampled   <= 1'b0;
		end else if (mod_reset) begin
			bit_cnt <= 4'h0;
			sampled <= 1'b0;
			// slave reply may be preloaded while deselected
			if (accept_write) begin
				shift_reg <= buf_wdata_i;
			end
		end else begin
			if (accept_write) begin
				shift_reg <= buf_wdata_i;
				sampled   <= 1'b0;
			end
			if (sample_edge) begin
				in_bit  <= sdi_bit;
				sampled <= 1'b1;
				if (!late_sample) begin
					shift_reg <= {shift_reg[6:0], sdi_bit};
					bit_cnt   <= byte_done ? 4'h0 : bit_cnt + 4'h1;
				end
			end
			if (shift_edge && late_sample && sampled) begin
				shift_reg <= {shift_reg[6:0], in_bit};
				bit_cnt   <= byte_done ? 4'h0 : bit_cnt + 4'h1;
			end
		end
	end

	// ==========================================================
	// receive buffer and status flags
	// ==========================================================
	logic [7:0] done_byte;
	assign done_byte = late_sample ? {shift_reg[6:0], in_bit} : {shift_reg[6:0], sdi_bit};
	// buffer: written by software or by a completed byte
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_buffer_o     <= spi_port_pkg::RESET_BYTE;
			buffer_full_o     <= 1'b0;
			xfer_flag_o       <= 1'b0;
			write_collision_o <= 1'b0;
		end else begin
			if (byte_done && !mod_reset) begin
				data_buffer_o <= done_byte;
			end else if (accept_write) begin
				data_buffer_o <= buf_wdata_i;
			end
			// set wins over read clear
			if (byte_done && !mod_reset) begin
				buffer_full_o <= 1'b1;
			end else if (buf_read_i) begin
				buffer_full_o <= 1'b0;
			end
			// completion flag sets on a completed byte whatever sleep_i is; sleep_i is not used
			if (byte_done && !mod_reset) begin
				xfer_flag_o <= 1'b1;
			end else if (xfer_flag_clear_i) begin
				xfer_flag_o <= 1'b0;
			end
			if (write_try && xfer_busy) begin
				write_collision_o <= 1'b1;
			end else if (write_collision_clear_i) begin
				write_collision_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// pin drivers
	// ==========================================================
	// msb presented before first edge when edge select set
	assign sdo_o      = shift_reg[7];
	// output enable low while driving; float when deselected
	assign sdo_oe_n_o = !(en && ss_active);
	assign sck_o      = en ? sck_int : clock_polarity_i;
	assign sck_oe_n_o = !(en && is_master);
endmodule : spi_master_slave_port

// *** spi_port_props.sv ***
// checker for the spi port, watching the top ports only
// assumes the bind at the foot onto spi_master_slave_port
`timescale 1ns/100ps
module spi_port_props (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       port_enable_i,
	input wire logic       clock_polarity_i,
	input wire logic [3:0] mode_select_i,
	input wire logic [7:0] baud_reload_i,
	input wire logic       buf_write_i,
	input wire logic [7:0] buf_wdata_i,
	input wire logic       buf_read_i,
	input wire logic       write_collision_clear_i,
	input wire logic [7:0] data_buffer_o,
	input wire logic       buffer_full_o,
	input wire logic       write_collision_o,
	input wire logic       xfer_flag_o,
	input wire logic       busy_o,
	input wire logic       sck_o,
	input wire logic       sck_oe_n_o,
	input wire logic       sdo_o,
	input wire logic       sdo_oe_n_o,
	input wire logic       ss_n_i
);
	logic       mst;
	logic       ok_wr;
	logic       tog;
	logic [8:0] half;
	logic [8:0] cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// master mode (slave codes are 4 and 5), accepted write, half period
	assign mst = mode_select_i[3:1] != 3'h2;
	assign ok_wr = port_enable_i && buf_write_i && !busy_o && !write_collision_o;
	assign half = mode_select_i == 4'h0 ? 9'h002 : mode_select_i == 4'h1 ? 9'h008 : mode_select_i == 4'h2 ? 9'h020 :
		mode_select_i == 4'ha ? {baud_reload_i, 1'b0} + 9'h002 : 9'h000;
	// cycles since the last serial clock change within a byte
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 9'h000;
			tog <= 1'b0;
		end else begin
			cnt <= $changed(sck_o) ? 9'h000 : cnt + 9'h001;
			tog <= busy_o && (tog || $changed(sck_o));
		end
	end
	// ====
	// properties
	property p_off; !port_enable_i && !$past(port_enable_i) |-> sck_oe_n_o && sdo_oe_n_o; endproperty
	a_off: assert property (p_off) else $error("pins driven while disabled");
	property p_write_collision; port_enable_i && buf_write_i && busy_o |=> write_collision_o; endproperty
	a_write_collision: assert property (p_write_collision) else $error("busy write not flagged");
	property p_wstay; write_collision_o && !write_collision_clear_i |=> write_collision_o; endproperty
	a_wstay: assert property (p_wstay) else $error("collision flag lost");
	property p_refuse; mst && buf_write_i && write_collision_o && !busy_o |=> !busy_o; endproperty
	a_refuse: assert property (p_refuse) else $error("write taken with collision set");
	property p_load; ok_wr |=> data_buffer_o == $past(buf_wdata_i); endproperty
	a_load: assert property (p_load) else $error("buffer not loaded by write");
	property p_start; ok_wr && mst |=> ##[0:1] (busy_o && !sck_oe_n_o && !sdo_oe_n_o && sdo_o == data_buffer_o[7]);
	endproperty
	a_start: assert property (p_start) else $error("master did not start with msb");
	property p_half; $changed(sck_o) && tog && busy_o && half != 9'h000 |-> cnt == half - 9'h001; endproperty
	a_half: assert property (p_half) else $error("serial clock half period wrong");
	property p_done; port_enable_i && $past(port_enable_i) && mst && $fell(busy_o) |-> ##[0:1] (xfer_flag_o && buffer_full_o);
	endproperty
	a_done: assert property (p_done) else $error("byte end without flags");
	property p_idle; port_enable_i && $past(port_enable_i) && mst && !busy_o && !$past(busy_o) |-> sck_o == clock_polarity_i;
	endproperty
	a_idle: assert property (p_idle) else $error("serial clock idle level wrong");
	property p_read; buf_read_i && !busy_o && !buf_write_i |=> !buffer_full_o; endproperty
	a_read: assert property (p_read) else $error("read left buffer full");
	property p_ss; port_enable_i && mode_select_i == 4'h4 && ss_n_i [*5] |-> sdo_oe_n_o; endproperty
	a_ss: assert property (p_ss) else $error("data out driven while deselected");
	c_master: cover property ($fell(busy_o) && mst);
	c_write_collision: cover property ($rose(write_collision_o));
	c_slave: cover property ($rose(xfer_flag_o) && !mst);
endmodule : spi_port_props
bind spi_master_slave_port spi_port_props chk (.clk_i(clk_i), .rst_i(rst_i), .port_enable_i(port_enable_i),
	.clock_polarity_i(clock_polarity_i), .mode_select_i(mode_select_i), .baud_reload_i(baud_reload_i),
	.buf_write_i(buf_write_i), .buf_wdata_i(buf_wdata_i), .buf_read_i(buf_read_i), .write_collision_clear_i(write_collision_clear_i),
	.data_buffer_o(data_buffer_o), .buffer_full_o(buffer_full_o), .write_collision_o(write_collision_o),
	.xfer_flag_o(xfer_flag_o), .busy_o(busy_o), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdo_o(sdo_o),
	.sdo_oe_n_o(sdo_oe_n_o), .ss_n_i(ss_n_i));

// *** spi_far_slave.sv ***
// far-end slave device for master-mode transfers
// assumes idle-low clock, data changed on the falling edge
`timescale 1ns/100ps
module spi_far_slave (
	input  wire logic       sck_i,
	input  wire logic       sel_n_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	logic [7:0] sh;
	initial miso_o = 1'b0;
	// load reply when selected; released line shows the inverse level
	always @(sel_n_i) begin
		if (!sel_n_i) begin
			sh = tx_i;
			miso_o = tx_i[7];
		end else begin
			miso_o = ~miso_o;
		end
	end
	// sample on rising edge, msb first
	always @(posedge sck_i) rx_o = {rx_o[6:0], mosi_i};
	// next bit out on the falling edge
	always @(negedge sck_i) begin
		sh = {sh[6:0], 1'b0};
		miso_o = sh[7];
	end
endmodule : spi_far_slave

// *** spi_master_slave_port_tb.sv ***
// self-checking bench for spi_master_slave_port
// assumes spi_far_slave as far end in master mode
`timescale 1ns/100ps
module spi_master_slave_port_tb;
	logic       clk_i, rst_i, en, cpol, sample_phase, cke, overwrite_enable, tick, slp, wr, rd, wclr, fclr;
	logic       tsck, tsdi, ss_n, psel_n, pmiso, sck_o, sck_oe_n, sdo, sdo_oe_n, sck_ln, sdi_ln, bf, write_collision, xf, busy;
	logic [3:0] mode;
	logic [7:0] rld, wd, ptx, prx, cap, dbuf;
	logic [3:0] modes [5];
	int         error_cnt, tests_run, cyc;
	// ====
	// pin wiring: clock fed back in master mode, slave data from bench
	assign sck_ln = sck_oe_n ? tsck : sck_o;
	assign sdi_ln = mode == spi_port_pkg::MODE_SLAVE_SEL ? tsdi : pmiso;
	spi_master_slave_port uut (.clk_i(clk_i), .rst_i(rst_i), .port_enable_i(en), .clock_polarity_i(cpol),
		.mode_select_i(mode), .sample_phase_i(sample_phase), .clock_edge_select_i(cke), .overwrite_enable_i(overwrite_enable),
		.baud_reload_i(rld), .timer_two_tick_i(tick), .sleep_i(slp), .buf_write_i(wr), .buf_wdata_i(wd),
		.buf_read_i(rd), .write_collision_clear_i(wclr), .xfer_flag_clear_i(fclr), .data_buffer_o(dbuf), .buffer_full_o(bf),
		.write_collision_o(write_collision), .xfer_flag_o(xf), .busy_o(busy), .sck_i(sck_ln), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n), .sdi_i(sdi_ln), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .ss_n_i(ss_n));
	spi_far_slave far (.sck_i(sck_ln), .sel_n_i(psel_n), .mosi_i(sdo), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
	// clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// timer source and hang limit
	always @(posedge clk_i) begin
		cyc++;
		if (rst_i) tick <= 1'b0;
		else if (cyc % 10 == 9) tick <= ~tick;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// ====
	// tasks
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tk
	task automatic setup(input logic [3:0] m);
		en <= 1'b0;
		tk(1);
		mode <= m;
		tk(1);
		en <= 1'b1;
		tk(1);
	endtask : setup
	task automatic put(input logic [7:0] d);
		wr <= 1'b1;
		wd <= d;
		tk(1);
		wr <= 1'b0;
	endtask : put
	task automatic wait_idle();
		int n;
		n = 0;
		tk(1);
		while (busy !== 1'b0 && n < 5000) begin
			tk(1);
			n++;
		end
		if (n == 5000) error_cnt++;
		tk(3);
	endtask : wait_idle
	task automatic xfer(input logic [7:0] d, input logic [7:0] r);
		ptx <= r;
		tk(1);
		psel_n <= 1'b0;
		tk(1);
		put(d);
		wait_idle();
		psel_n <= 1'b1;
		chk8(prx, d);
		chk8(dbuf, r);
		chk1(xf, 1'b1);
		rd <= 1'b1;
		fclr <= 1'b1;
		tk(1);
		rd <= 1'b0;
		fclr <= 1'b0;
		tk(1);
		chk1(bf, 1'b0);
	endtask : xfer
	task automatic sbyte(input logic [7:0] s, input int nb);
		ss_n <= 1'b0;
		tk(8);
		for (int b = 7; b > 7 - nb; b--) begin
			tsdi <= s[b];
			tk(8);
			tsck <= 1'b1;
			cap <= {cap[6:0], sdo};
			tk(8);
			tsck <= 1'b0;
		end
		tk(12);
		ss_n <= 1'b1;
		tsdi <= ~tsdi;
	endtask : sbyte
	task automatic close_out();
		$display("errors %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	// ====
	// main sequence
	initial begin
		{en, cpol, sample_phase, overwrite_enable, slp, wr, rd, wclr, fclr, tsck, tsdi} = 11'h000;
		{rst_i, cke, ss_n, psel_n} = 4'hf;
		mode = 4'h0;
		rld = 8'h02;
		wd = 8'h00;
		ptx = 8'h00;
		cap = 8'h00;
		modes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
		tk(5);
		rst_i <= 1'b0;
		// one master byte per rate choice
		for (int i = 0; i < 5; i++) begin
			setup(modes[i]);
			xfer(8'ha5 - 8'(i), 8'h3c + 8'(i));
		end
		// end-of-output sampling, changed only while disabled
		sample_phase <= 1'b1;
		setup(spi_port_pkg::MODE_MASTER_DIV16);
		xfer(8'h4b, 8'hd2);
		// write during transfer, refused write, then overwrite without read
		setup(spi_port_pkg::MODE_MASTER_DIV64);
		overwrite_enable <= 1'b1;
		ptx <= 8'hc3;
		psel_n <= 1'b0;
		tk(1);
		put(8'h5e);
		tk(10);
		put(8'h11);
		tk(2);
		chk1(write_collision, 1'b1);
		wait_idle();
		psel_n <= 1'b1;
		chk8(prx, 8'h5e);
		chk8(dbuf, 8'hc3);
		put(8'h22);
		tk(2);
		chk1(busy, 1'b0);
		wclr <= 1'b1;
		tk(1);
		wclr <= 1'b0;
		tk(1);
		chk1(write_collision, 1'b0);
		xfer(8'h77, 8'h9a);
		// slave with select, asleep; full byte, aborted byte, then full byte
		sample_phase <= 1'b0;
		setup(spi_port_pkg::MODE_SLAVE_SEL);
		put(8'h5a);
		slp <= 1'b1;
		tk(4);
		sbyte(8'h96, 8);
		chk8(dbuf, 8'h96);
		chk8(cap, 8'h5a);
		chk1(xf, 1'b1);
		tk(6);
		chk1(sdo_oe_n, 1'b1);
		rd <= 1'b1;
		fclr <= 1'b1;
		tk(1);
		rd <= 1'b0;
		fclr <= 1'b0;
		sbyte(8'hff, 3);
		tk(6);
		sbyte(8'h69, 8);
		chk8(dbuf, 8'h69);
		close_out();
	end
endmodule : spi_master_slave_port_tb
